// >>> hw/ririq_ana_change.sv
`timescale 1ns/1ps
module ririq_ana_change (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic osc_good,
    input  wire logic synth_lock,
    input  wire logic field_present_good,
    output logic      changed
);
    logic [2:0] prev_reg;
    logic [2:0] prev_next;
    logic       primed_reg;
    logic       primed_next;
    logic [2:0] now_lvl;

    assign now_lvl = {osc_good, synth_lock, field_present_good};

    always_comb begin
        prev_next   = now_lvl;
        primed_next = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg   <= 3'h0;
            primed_reg <= 1'b0;
        end else if (ce) begin
            prev_reg   <= prev_next;
            primed_reg <= primed_next;
        end
    end

    // rising or falling edge on any indicator
    assign changed = primed_reg && (now_lvl != prev_reg);
endmodule

// >>> hw/ririq_flag_byte.sv
`timescale 1ns/1ps
`include "ririq_params.svh"
module ririq_flag_byte
    import ririq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        hold_clr,
    input  wire logic        rd_clr,
    input  wire ririq_byte_t set_bits,
    output ririq_byte_t      flags
);
    ririq_byte_t flags_reg;
    ririq_byte_t flags_next;

    // per bit sticky flag, set beats read clear, hold clear beats set
    for (genvar i = 0; i < 8; i++) begin : g_bit
        always_comb begin
            if (hold_clr) begin
                flags_next[i] = 1'b0;
            end else begin
                flags_next[i] = (flags_reg[i] & ~rd_clr) | set_bits[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_reg <= `RIRIQ_RST_FLAGS;
        end else if (ce) begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// >>> hw/ririq_params.svh
`ifndef RIRIQ_PARAMS_SVH
`define RIRIQ_PARAMS_SVH

// register offsets
`define RIRIQ_ADDR_ENABLE1   8'h35
`define RIRIQ_ADDR_ENABLE2   8'h36
`define RIRIQ_ADDR_PRIMARY   8'h37
`define RIRIQ_ADDR_SECONDARY 8'h38
`define RIRIQ_ADDR_OPTION    8'h3A

// reset values
`define RIRIQ_RST_FLAGS      8'h00
`define RIRIQ_RST_ENABLE1    8'hF7
`define RIRIQ_RST_ENABLE2    8'h40
`define RIRIQ_RST_OPTION     8'h00
`define RIRIQ_RDATA_IDLE     8'h00

// primary flag positions
`define RIRIQ_P_TX_DONE      7
`define RIRIQ_P_RX_DONE      6
`define RIRIQ_P_FIFO_LEVEL   5
`define RIRIQ_P_ERROR        4
`define RIRIQ_P_HEADER       3
`define RIRIQ_P_ACK_DONE     1
`define RIRIQ_P_NO_RESPONSE  0

// secondary flag positions
`define RIRIQ_S_ANALOG       7
`define RIRIQ_S_CMD_DONE     6
`define RIRIQ_S_CRC_FAIL     2
`define RIRIQ_S_LEN_PROTO    1
`define RIRIQ_S_PRE_OVFL     0

// option register field
`define RIRIQ_O_SECOND_BYTE  6

// fifo fill thresholds in bytes
`define RIRIQ_FIFO_TX_LOW    5'h06
`define RIRIQ_FIFO_RX_HIGH   5'h12

`endif

// >>> hw/ririq_pkg.sv
package ririq_pkg;
    typedef logic [7:0] ririq_byte_t;
    typedef logic [4:0] ririq_count_t;
    typedef enum logic [2:0] {
        RIRIQ_SEL_NONE      = 3'b000,
        RIRIQ_SEL_ENABLE1   = 3'b001,
        RIRIQ_SEL_ENABLE2   = 3'b010,
        RIRIQ_SEL_PRIMARY   = 3'b011,
        RIRIQ_SEL_SECONDARY = 3'b100,
        RIRIQ_SEL_OPTION    = 3'b101
    } ririq_sel_e;
endpackage

// >>> hw/ririq_status.sv
`timescale 1ns/1ps
`include "ririq_params.svh"
module ririq_status
    import ririq_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         chip_en,
    input  wire logic [7:0]   addr,
    input  wire ririq_byte_t  wdata,
    input  wire logic         wr_stb,
    input  wire logic         rd_stb,
    output ririq_byte_t       rdata,
    input  wire logic         tx_done,
    input  wire logic         rx_done,
    input  wire logic         tx_active,
    input  wire logic         rx_active,
    input  wire ririq_count_t fifo_level,
    input  wire logic         header_bit_rx,
    input  wire logic         header_bit_val,
    input  wire logic         two_bytes_in_fifo,
    input  wire logic         err_crc,
    input  wire logic         err_len_proto,
    input  wire logic         err_preamble,
    input  wire logic         err_fifo_ovfl,
    input  wire logic         ack_cmd_sent,
    input  wire logic         ack_end_ok,
    input  wire logic         ack_end_timeout,
    input  wire logic         ack_end_rx_err,
    input  wire logic         noresp_expired,
    input  wire logic         osc_good,
    input  wire logic         synth_lock,
    input  wire logic         field_present_good,
    input  wire logic         cmd_done,
    output logic              irq,
    output logic              rx_abort,
    output logic              raw_fifo_second_byte_option,
    output ririq_byte_t       primary_event_flags,
    output ririq_byte_t       secondary_event_flags
);
    ririq_byte_t enable1_reg;
    ririq_byte_t enable1_next;
    ririq_byte_t enable2_reg;
    ririq_byte_t enable2_next;
    ririq_byte_t option_reg;
    ririq_byte_t option_next;
    ririq_byte_t rdata_reg;
    ririq_byte_t rdata_next;
    logic        fifo_cond_reg;
    logic        fifo_cond_next;
    logic        rx_abort_reg;
    logic        rx_abort_next;
    ririq_sel_e  sel;
    ririq_byte_t pri_set;
    ririq_byte_t sec_set;
    logic        pri_clr;
    logic        sec_clr;
    logic        fifo_cond;
    logic        err_any;
    logic        ana_changed;
    logic        second_opt;

    // address decode
    always_comb begin
        unique case (addr)
            `RIRIQ_ADDR_ENABLE1:   sel = RIRIQ_SEL_ENABLE1;
            `RIRIQ_ADDR_ENABLE2:   sel = RIRIQ_SEL_ENABLE2;
            `RIRIQ_ADDR_PRIMARY:   sel = RIRIQ_SEL_PRIMARY;
            `RIRIQ_ADDR_SECONDARY: sel = RIRIQ_SEL_SECONDARY;
            `RIRIQ_ADDR_OPTION:    sel = RIRIQ_SEL_OPTION;
            default:               sel = RIRIQ_SEL_NONE;
        endcase
    end

    assign second_opt = option_reg[`RIRIQ_O_SECOND_BYTE];
    assign raw_fifo_second_byte_option = second_opt;

    assign fifo_cond = (tx_active && (fifo_level < `RIRIQ_FIFO_TX_LOW))
                    || (rx_active && (fifo_level > `RIRIQ_FIFO_RX_HIGH));
    assign err_any   = err_crc | err_len_proto | err_preamble | err_fifo_ovfl;

    ririq_ana_change u_ana (
        .clk                (clk),
        .rst_n              (rst_n),
        .ce                 (ce),
        .osc_good           (osc_good),
        .synth_lock         (synth_lock),
        .field_present_good (field_present_good),
        .changed            (ana_changed)
    );

    // primary set terms, independent of enables
    always_comb begin
        pri_set = 8'h00;
        pri_set[`RIRIQ_P_TX_DONE] = tx_done;
        pri_set[`RIRIQ_P_RX_DONE] = rx_done;
        pri_set[`RIRIQ_P_FIFO_LEVEL] = fifo_cond && !fifo_cond_reg;
        pri_set[`RIRIQ_P_ERROR] = err_any;
        pri_set[`RIRIQ_P_HEADER] = second_opt ? two_bytes_in_fifo : (header_bit_rx && header_bit_val);
        pri_set[`RIRIQ_P_ACK_DONE] = ack_end_ok || (ack_cmd_sent && (ack_end_timeout || ack_end_rx_err));
        pri_set[`RIRIQ_P_NO_RESPONSE] = noresp_expired;
    end

    // secondary set terms
    always_comb begin
        sec_set = 8'h00;
        sec_set[`RIRIQ_S_ANALOG] = ana_changed;
        sec_set[`RIRIQ_S_CMD_DONE] = cmd_done;
        sec_set[`RIRIQ_S_CRC_FAIL]  = err_crc;
        sec_set[`RIRIQ_S_LEN_PROTO] = err_len_proto;
        sec_set[`RIRIQ_S_PRE_OVFL] = err_preamble || err_fifo_ovfl;
    end

    assign pri_clr = rd_stb && (sel == RIRIQ_SEL_PRIMARY);
    assign sec_clr = rd_stb && (sel == RIRIQ_SEL_SECONDARY);

    ririq_flag_byte u_primary (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .hold_clr (!chip_en),
        .rd_clr   (pri_clr),
        .set_bits (pri_set),
        .flags    (primary_event_flags)
    );

    ririq_flag_byte u_secondary (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .hold_clr (!chip_en),
        .rd_clr   (sec_clr),
        .set_bits (sec_set),
        .flags    (secondary_event_flags)
    );

    // register writes and read data
    always_comb begin
        enable1_next   = enable1_reg;
        enable2_next   = enable2_reg;
        option_next    = option_reg;
        rdata_next     = `RIRIQ_RDATA_IDLE;
        fifo_cond_next = fifo_cond;
        rx_abort_next  = noresp_expired && enable1_reg[`RIRIQ_P_NO_RESPONSE];
        if (wr_stb) begin
            unique case (sel)
                RIRIQ_SEL_ENABLE1: enable1_next = wdata;
                RIRIQ_SEL_ENABLE2: enable2_next = wdata;
                RIRIQ_SEL_OPTION:  option_next  = wdata & (8'h01 << `RIRIQ_O_SECOND_BYTE);
                default:           enable1_next = enable1_reg;
            endcase
        end
        if (rd_stb) begin
            unique case (sel)
                RIRIQ_SEL_ENABLE1:   rdata_next = enable1_reg;
                RIRIQ_SEL_ENABLE2:   rdata_next = enable2_reg;
                RIRIQ_SEL_PRIMARY:   rdata_next = primary_event_flags;
                RIRIQ_SEL_SECONDARY: rdata_next = secondary_event_flags;
                RIRIQ_SEL_OPTION:    rdata_next = option_reg;
                default:             rdata_next = `RIRIQ_RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable1_reg   <= `RIRIQ_RST_ENABLE1;
            enable2_reg   <= `RIRIQ_RST_ENABLE2;
            option_reg    <= `RIRIQ_RST_OPTION;
            rdata_reg     <= `RIRIQ_RDATA_IDLE;
            fifo_cond_reg <= 1'b0;
            rx_abort_reg  <= 1'b0;
        end else if (ce) begin
            enable1_reg   <= enable1_next;
            enable2_reg   <= enable2_next;
            option_reg    <= option_next;
            rdata_reg     <= rdata_next;
            fifo_cond_reg <= fifo_cond_next;
            rx_abort_reg  <= rx_abort_next;
        end
    end

    assign rdata    = rdata_reg;
    assign rx_abort = rx_abort_reg;
    assign irq = |(primary_event_flags & enable1_reg) || |(secondary_event_flags & enable2_reg);

    // checks
    sequence s_live;
        ce && chip_en;
    endsequence

    sequence s_ack_fail;
        ack_cmd_sent && (ack_end_timeout || ack_end_rx_err);
    endsequence

    sequence s_quiet_primary;
        !tx_done && !rx_done && !err_any && !noresp_expired && !ack_end_ok
        && !header_bit_rx && !two_bytes_in_fifo && !fifo_cond && !ack_end_timeout && !ack_end_rx_err;
    endsequence

    a_tx_done_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and tx_done |=> primary_event_flags[7])
        else $error("transmit done flag not set");

    a_rx_done_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and rx_done |=> primary_event_flags[6])
        else $error("receive done flag not set");

    a_fifo_level_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and (tx_active && !rx_active && fifo_level == 5'h05 && !fifo_cond_reg)
        |=> primary_event_flags[5])
        else $error("fifo level flag not set");

    a_error_both: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and err_crc |=> primary_event_flags[4] && secondary_event_flags[2])
        else $error("error summary or detail missing");

    a_ack_fail_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and s_ack_fail |=> primary_event_flags[1])
        else $error("ack done flag missing after failure");

    a_noresp_abort: assert property (@(posedge clk) disable iff (!rst_n)
        ce && noresp_expired |=> rx_abort == $past(enable1_reg[0]) && (!$past(chip_en) || primary_event_flags[0]))
        else $error("no-response abort mismatch");

    a_chip_off_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !chip_en |=> primary_event_flags == 8'h00 && secondary_event_flags == 8'h00)
        else $error("flags not cleared with chip disabled");

    a_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and rd_stb && addr == `RIRIQ_ADDR_PRIMARY and s_quiet_primary
        |=> (rdata == $past(primary_event_flags) && primary_event_flags == 8'h00)
        ##1 (rdata == 8'h00 || $past(rd_stb) || !$past(ce)))
        else $error("primary read did not clear or answer");

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and rd_stb && addr == 8'h38 && cmd_done |=> secondary_event_flags[6])
        else $error("event lost during read clear");

    a_irq_pin: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and tx_done && enable1_reg[7] && !wr_stb |=> irq)
        else $error("interrupt pin not raised");

    a_header_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and !second_opt && header_bit_rx && header_bit_val |=> primary_event_flags[`RIRIQ_P_HEADER])
        else $error("header flag not set");

    a_second_byte: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and second_opt && two_bytes_in_fifo |=> primary_event_flags[`RIRIQ_P_HEADER])
        else $error("second byte flag not set");

    a_cmd_done_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and cmd_done |=> secondary_event_flags[`RIRIQ_S_CMD_DONE])
        else $error("command done flag not set");

    a_overflow_both: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and err_fifo_ovfl |=> primary_event_flags[`RIRIQ_P_ERROR] && secondary_event_flags[`RIRIQ_S_PRE_OVFL])
        else $error("overflow summary or detail missing");

    a_analog_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and $past(rst_n) && $past(ce) && ($changed(osc_good) || $changed(synth_lock)
        || $changed(field_present_good)) |=> secondary_event_flags[`RIRIQ_S_ANALOG])
        else $error("analog change flag not set");

    a_irq_drop: assert property (@(posedge clk) disable iff (!rst_n)
        s_live and rd_stb && !wr_stb && addr == `RIRIQ_ADDR_PRIMARY && !cmd_done && !ana_changed
        && (secondary_event_flags & enable2_reg) == 8'h00 and s_quiet_primary |=> !irq)
        else $error("interrupt kept after read clear");
endmodule

// >>> sim/ririq_host_model.sv
`timescale 1ns/1ps
`include "ririq_params.svh"
module ririq_host_model
    import ririq_pkg::*;
(
    input  wire logic        clk,
    input  wire ririq_byte_t rdata,
    output logic [7:0]       addr,
    output ririq_byte_t      wdata,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic             got_v,
    output ririq_byte_t      got_data
);
    logic rd_pend;

    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // read data taken in the one cycle it stands
    always @(posedge clk) begin
        rd_pend <= rd_stb;
        got_v <= rd_pend;
        if (rd_pend) begin
            got_data <= rdata;
        end
    end

    task automatic write_reg(input logic [7:0] a, input ririq_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask

    task automatic inventory_setup();
        write_reg(`RIRIQ_ADDR_ENABLE1, 8'h10);
        write_reg(`RIRIQ_ADDR_ENABLE2, 8'h00);
    endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "ririq_params.svh"
module testbench
    import ririq_pkg::*;
();
    logic         clk, rst_n, ce, chip_en, tx_active, rx_active, header_bit_val, ack_cmd_sent;
    logic         wr_stb, rd_stb, got_v, irq, rx_abort, opt;
    logic [12:0]  ev;
    logic [2:0]   ana;
    logic [7:0]   addr;
    ririq_count_t fifo_level;
    ririq_byte_t  rdata, wdata, got_data, e1, e2, p, pf, sf;
    ririq_byte_t  ep [13];
    ririq_byte_t  es [13];
    ririq_byte_t  expq [$];
    int           miscompares, tests_run;

    ririq_status uut (
        .clk, .rst_n, .ce, .chip_en, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .tx_done(ev[0]), .rx_done(ev[1]), .tx_active, .rx_active, .fifo_level,
        .header_bit_rx(ev[6]), .header_bit_val, .two_bytes_in_fifo(ev[10]),
        .err_crc(ev[2]), .err_len_proto(ev[3]), .err_preamble(ev[4]), .err_fifo_ovfl(ev[5]),
        .ack_cmd_sent, .ack_end_ok(ev[7]), .ack_end_timeout(ev[11]), .ack_end_rx_err(ev[12]),
        .noresp_expired(ev[8]), .osc_good(ana[0]), .synth_lock(ana[1]), .field_present_good(ana[2]),
        .cmd_done(ev[9]), .irq, .rx_abort, .raw_fifo_second_byte_option(opt),
        .primary_event_flags(pf), .secondary_event_flags(sf)
    );

    ririq_host_model host (.clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb, .got_v, .got_data);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input ririq_byte_t e, input ririq_byte_t g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // read results come back in request order
    always @(negedge clk) begin
        if (got_v === 1'b1) begin
            if (expq.size() == 0) begin
                chk("spare read", 8'h00, 8'hFF);
            end else begin
                chk("rdata", expq.pop_front(), got_data);
            end
        end
    end

    task automatic rd(input logic [7:0] a, input ririq_byte_t e);
        expq.push_back(e);
        host.read_reg(a);
    endtask

    task automatic wr(input logic [7:0] a, input ririq_byte_t d);
        if (a == `RIRIQ_ADDR_ENABLE1) e1 = d;
        if (a == `RIRIQ_ADDR_ENABLE2) e2 = d;
        host.write_reg(a, d);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= '0;
        @(negedge clk);
    endtask

    task automatic fire(input int i, input ririq_byte_t pe, input ririq_byte_t se, input logic ab);
        pulse(i);
        chk("irq", {7'h00, |(pe & e1) | |(se & e2)}, {7'h00, irq});
        chk("rx_abort", {7'h00, ab}, {7'h00, rx_abort});
        chk("primary flags", pe, pf);
        chk("secondary flags", se, sf);
        rd(`RIRIQ_ADDR_PRIMARY, pe);
        rd(`RIRIQ_ADDR_SECONDARY, se);
        @(negedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        rd(`RIRIQ_ADDR_PRIMARY, 8'h00);
    endtask

    task automatic fstep(input logic tx, input logic rx, input ririq_count_t lvl, input ririq_byte_t e);
        @(posedge clk);
        tx_active <= tx;
        rx_active <= rx;
        fifo_level <= lvl;
        rd(`RIRIQ_ADDR_PRIMARY, e);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        {rst_n, tx_active, rx_active, header_bit_val, ack_cmd_sent} = '0;
        {ce, chip_en} = 2'b11;
        ev = '0;
        ana = '0;
        fifo_level = '0;
        e1 = 8'hF7;
        e2 = 8'h40;
        ep = '{8'h80, 8'h40, 8'h10, 8'h10, 8'h10, 8'h10, 8'h08, 8'h02, 8'h01, 8'h00, 8'h00, 8'h02, 8'h02};
        es = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
        miscompares = 0;
        tests_run = 0;
        void'($urandom(10855));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(`RIRIQ_ADDR_ENABLE1, 8'hF7);
        rd(`RIRIQ_ADDR_ENABLE2, 8'h40);
        rd(`RIRIQ_ADDR_OPTION, 8'h00);
        rd(`RIRIQ_ADDR_PRIMARY, 8'h00);
        rd(`RIRIQ_ADDR_SECONDARY, 8'h00);
        rd(8'h50, 8'h00);
        wr(`RIRIQ_ADDR_PRIMARY, 8'hFF);
        rd(`RIRIQ_ADDR_PRIMARY, 8'h00);
        @(posedge clk);
        ack_cmd_sent <= 1'b1;
        header_bit_val <= 1'b1;
        for (int i = 0; i < 13; i++) fire(i, ep[i], es[i], i == 8);
        wr(`RIRIQ_ADDR_OPTION, 8'hFF);
        rd(`RIRIQ_ADDR_OPTION, 8'h40);
        chk("option", 8'h01, {7'h00, opt});
        ack_cmd_sent <= 1'b0;
        wr(`RIRIQ_ADDR_ENABLE1, 8'($urandom()) & 8'hFE);
        wr(`RIRIQ_ADDR_ENABLE2, 8'($urandom()));
        for (int i = 0; i < 13; i++) begin
            p = (i == 6 || i > 10) ? 8'h00 : (i == 10) ? 8'h08 : ep[i];
            fire(i, p, es[i], 1'b0);
        end
        wr(`RIRIQ_ADDR_OPTION, 8'h00);
        fstep(1'b1, 1'b0, 5'h06, 8'h00);
        fstep(1'b1, 1'b0, 5'h05, 8'h20);
        fstep(1'b0, 1'b1, 5'h12, 8'h00);
        fstep(1'b0, 1'b1, 5'h13, 8'h20);
        fstep(1'b0, 1'b0, 5'h00, 8'h00);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            ana[i % 3] <= ~ana[i % 3];
            rd(`RIRIQ_ADDR_SECONDARY, 8'h80);
        end
        pulse(0);
        @(posedge clk);
        chip_en <= 1'b0;
        ev[9] <= 1'b1;
        @(posedge clk);
        chip_en <= 1'b1;
        ev <= '0;
        rd(`RIRIQ_ADDR_PRIMARY, 8'h00);
        rd(`RIRIQ_ADDR_SECONDARY, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        ev[0] <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        ev <= '0;
        rd(`RIRIQ_ADDR_PRIMARY, 8'h00);
        fork
            pulse(0);
            rd(`RIRIQ_ADDR_PRIMARY, 8'h00);
        join
        rd(`RIRIQ_ADDR_PRIMARY, 8'h80);
        fork
            pulse(9);
            rd(`RIRIQ_ADDR_SECONDARY, 8'h00);
        join
        rd(`RIRIQ_ADDR_SECONDARY, 8'h40);
        host.inventory_setup();
        e1 = 8'h10;
        e2 = 8'h00;
        pulse(2);
        chk("irq", 8'h01, {7'h00, irq});
        rd(`RIRIQ_ADDR_PRIMARY, 8'h10);
        @(negedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        rd(`RIRIQ_ADDR_SECONDARY, 8'h04);
        repeat (4) @(posedge clk);
        chk("pending reads", 8'h00, 8'(expq.size()));
        give_verdict();
    end
endmodule
